// ==== adcseq_params.svh ====
// Constants of the conversion and power sequencer: register offsets,
// field positions, reset values and timing counts.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.
`ifndef ADCSEQ_PARAMS_SVH
`define ADCSEQ_PARAMS_SVH

// Register byte offsets
`define ADCSEQ_CTRL_OFS 12'h000
`define ADCSEQ_CONF_OFS 12'h004
`define ADCSEQ_KEEP_OFS 12'h008
`define ADCSEQ_STAT_OFS 12'h00c
`define ADCSEQ_RES_OFS 12'h010
`define ADCSEQ_PWR_OFS 12'h014

// Control register fields
`define ADCSEQ_GO_BIT 0
`define ADCSEQ_CONT_BIT 1
`define ADCSEQ_CHOP_BIT 2
`define ADCSEQ_SRC_LSB 3
`define ADCSEQ_REFSEL_BIT 5
`define ADCSEQ_GAINSEL_BIT 6
`define ADCSEQ_BIAS_SOURCE_SELECT_BIT 7

// Configuration register fields
`define ADCSEQ_MODULATOR_CLOCK_DIVIDER_LSB 0
`define ADCSEQ_OSR_LSB 2
`define ADCSEQ_REJ_LSB 4

// Keep-alive bits
`define ADCSEQ_KEEP_TEMP 0
`define ADCSEQ_KEEP_CONV 1
`define ADCSEQ_KEEP_REF 2
`define ADCSEQ_KEEP_GAIN 3
`define ADCSEQ_KEEP_OSC 4
`define ADCSEQ_KEEP_AMPA 5
`define ADCSEQ_KEEP_AMPB 6
`define ADCSEQ_KEEP_BIAS 7

// Reset values
`define ADCSEQ_CTRL_RST 8'h00
`define ADCSEQ_CONF_RST 6'h00
`define ADCSEQ_KEEP_RST 8'h00

// Timing
`define ADCSEQ_SYS_HZ 200000000
`define ADCSEQ_FMOD_HZ 153600
`define ADCSEQ_MOD_DIV (`ADCSEQ_SYS_HZ / `ADCSEQ_FMOD_HZ)
`define ADCSEQ_WAKE_MOD_TICKS 20
`define ADCSEQ_CAL_CYCLES 70
`define ADCSEQ_CLK_WAKE_US 450
`define ADCSEQ_CLK_WAKE_CYCLES ((`ADCSEQ_CLK_WAKE_US * 1000) / 5)
`define ADCSEQ_PERIODS_PLAIN 3
`define ADCSEQ_PERIODS_CHOP 6
`define ADCSEQ_NEXT_PLAIN 1
`define ADCSEQ_NEXT_CHOP 3

`endif

// ==== adcseq_pkg.sv ====
// Types of the conversion and power sequencer.
// Assumes adcseq_params.svh supplies the numeric constants.
package adcseq_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CLK_WAKE = 4'b0010,
    ST_MOD_WAKE = 4'b0100,
    ST_RUN = 4'b1000
  } adcseq_state_type;

  // Input source codes
  typedef enum logic [1:0] {
    SRC_TEMP = 2'b00,
    SRC_SENSOR = 2'b01,
    SRC_AUX = 2'b10,
    SRC_NONE = 2'b11
  } adcseq_src_type;

  // Block power enables, high means operate
  typedef struct packed {
    logic bias_resistor_block;
    logic amplifier_b;
    logic amplifier_a;
    logic system_clock_source;
    logic front_gain_stage;
    logic internal_reference;
    logic converter;
    logic temp_sensor;
  } adcseq_power_type;

endpackage : adcseq_pkg

// ==== adcseq_top.sv ====
// Conversion timing and block power sequencer with an APB register file.
// Assumes the 200 MHz clock stands for the system oscillator and that the
// correction datapath presents its result on corrected_data_in.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "adcseq_params.svh"

module adcseq_top import adcseq_pkg::*; #(
  parameter int MOD_DIV = `ADCSEQ_MOD_DIV,
  parameter int CLK_WAKE_CYCLES = `ADCSEQ_CLK_WAKE_CYCLES,
  parameter int MAX_DECIM = 768
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Correction datapath
  input wire logic [15:0] corrected_data_in,
  output logic filter_done_out,
  output logic result_update_out,
  // Analog control
  output logic chop_swap_out,
  output logic mod_clock_en_out,
  output adcseq_power_type power_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // The divider and decimation counters are 16 and 10 bits wide
  if (MOD_DIV < 1 || MOD_DIV > 8191) begin : g_bad_div
    $error("MOD_DIV out of range");
  end
  if (MAX_DECIM != 768) begin : g_bad_decim
    $error("decimation table supports 768 only");
  end
  if (CLK_WAKE_CYCLES < 1 || CLK_WAKE_CYCLES > 1048575) begin : g_bad_wake
    $error("CLK_WAKE_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Decimation ratio from oversampling and rejection codes
  function automatic logic [9:0] decim_ratio(input logic [1:0] oversampling_code, input logic [1:0] rejection_code);
    logic [9:0] base;
    base = rejection_code[1] ? 10'h280 : 10'h300;
    decim_ratio = base >> oversampling_code;
  endfunction : decim_ratio

  // True when the address matches a register offset
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] ofs);
    addr_is = (addr == ofs);
  endfunction : addr_is

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] ctrl_reg; // Control register
  logic [5:0] conf_reg; // Divider and filter codes
  logic [7:0] keep_reg; // Block keep-alive bits
  logic [15:0] result_reg; // Latest corrected result
  logic ready_reg; // Result ready flag
  adcseq_state_type state_reg; // Sequencer state
  adcseq_state_type state_next; // Next sequencer state
  logic [19:0] wake_cnt_reg; // Clock wake-up count
  logic [15:0] div_cnt_reg; // Modulator divider count
  logic mod_tick; // One-cycle modulator clock enable
  logic [4:0] mwake_cnt_reg; // Modulator wake-up ticks
  logic [9:0] decim_cnt_reg; // Ticks within a period
  logic [2:0] period_cnt_reg; // Periods toward next result
  logic first_reg; // No result yet in this run
  logic [6:0] cal_cnt_reg; // Correction cycles left
  logic cal_busy_reg; // Correction running
  logic period_end; // Last tick of a period
  logic periods_met; // Enough periods for a result
  logic cal_done; // Correction finishes this cycle
  logic single_done; // Single conversion completes
  logic [2:0] periods_needed; // Periods before next result
  logic [1:0] src; // Input source select
  logic go; // Measure-go
  logic osc_run; // Oscillator running
  logic apb_setup; // Access phase cycle awaiting answer
  logic apb_done; // Transfer completes this edge
  logic wr_ok; // Write accepted this edge
  logic rd_result; // Result read completes this edge
  logic [15:0] div_top; // Modulator divide length
  adcseq_power_type power_next; // Next power enables

  assign go = ctrl_reg[`ADCSEQ_GO_BIT];
  assign src = ctrl_reg[`ADCSEQ_SRC_LSB +: 2];
  assign osc_run = go | keep_reg[`ADCSEQ_KEEP_OSC] | keep_reg[`ADCSEQ_KEEP_CONV];

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake

  // Answer in the second access cycle
  assign apb_setup = psel_in & penable_in & ~pready_out;
  assign apb_done = psel_in & penable_in & pready_out;

  // Only control and keep registers take writes while the oscillator is stopped
  assign wr_ok = apb_done & pwrite_in &
    (osc_run | addr_is(paddr_in, `ADCSEQ_CTRL_OFS) | addr_is(paddr_in, `ADCSEQ_KEEP_OFS));
  assign rd_result = apb_done & ~pwrite_in & addr_is(paddr_in, `ADCSEQ_RES_OFS);

  // Ready, read data and error answer
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= apb_setup;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      if (apb_setup) begin
        unique case (paddr_in)
          `ADCSEQ_CTRL_OFS: prdata_out <= {24'h000000, ctrl_reg};
          `ADCSEQ_CONF_OFS: prdata_out <= {26'h0000000, conf_reg};
          `ADCSEQ_KEEP_OFS: prdata_out <= {24'h000000, keep_reg};
          `ADCSEQ_STAT_OFS: prdata_out <= {26'h0000000, state_reg, ~(state_reg == ST_IDLE), ready_reg};
          `ADCSEQ_RES_OFS: prdata_out <= {16'h0000, result_reg};
          `ADCSEQ_PWR_OFS: prdata_out <= {24'h000000, power_out};
          default: pslverr_out <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  // Software writes; hardware clears measure-go after a single conversion
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg <= `ADCSEQ_CTRL_RST;
    end else if (wr_ok && addr_is(paddr_in, `ADCSEQ_CTRL_OFS)) begin
      ctrl_reg <= pwdata_in[7:0];
    end else if (single_done) begin
      ctrl_reg[`ADCSEQ_GO_BIT] <= 1'b0;
    end
  end

  // Divider and filter codes
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      conf_reg <= `ADCSEQ_CONF_RST;
    end else if (wr_ok && addr_is(paddr_in, `ADCSEQ_CONF_OFS)) begin
      conf_reg <= pwdata_in[5:0];
    end
  end

  // Keep-alive bits
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      keep_reg <= `ADCSEQ_KEEP_RST;
    end else if (wr_ok && addr_is(paddr_in, `ADCSEQ_KEEP_OFS)) begin
      keep_reg <= pwdata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state; a cleared measure-go always returns to idle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (go) begin
          if (!keep_reg[`ADCSEQ_KEEP_OSC]) begin
            state_next = ST_CLK_WAKE;
          end else begin
            state_next = ST_MOD_WAKE;
          end
        end
      end
      ST_CLK_WAKE: begin
        if (!go) begin
          state_next = ST_IDLE;
        end else if (wake_cnt_reg == 20'(CLK_WAKE_CYCLES - 1)) begin
          state_next = ST_MOD_WAKE;
        end
      end
      ST_MOD_WAKE: begin
        if (!go) begin
          state_next = ST_IDLE;
        end else if (mod_tick && mwake_cnt_reg == 5'(`ADCSEQ_WAKE_MOD_TICKS - 1)) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!go || single_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Oscillator wake-up counter
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_cnt_reg <= 20'h00000;
    end else if (state_reg == ST_CLK_WAKE) begin
      wake_cnt_reg <= wake_cnt_reg + 20'h00001;
    end else begin
      wake_cnt_reg <= 20'h00000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator clock

  // Divide length doubles per divider code step
  assign div_top = 16'(MOD_DIV) << conf_reg[`ADCSEQ_MODULATOR_CLOCK_DIVIDER_LSB +: 2];
  assign mod_tick = (div_cnt_reg == div_top - 16'h0001);

  // Divider runs only while the modulator is awake
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt_reg <= 16'h0000;
    end else if (state_reg == ST_MOD_WAKE || state_reg == ST_RUN) begin
      div_cnt_reg <= mod_tick ? 16'h0000 : div_cnt_reg + 16'h0001;
    end else begin
      div_cnt_reg <= 16'h0000;
    end
  end

  // Modulator wake-up ticks
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mwake_cnt_reg <= 5'h00;
    end else if (state_reg != ST_MOD_WAKE) begin
      mwake_cnt_reg <= 5'h00;
    end else if (mod_tick) begin
      mwake_cnt_reg <= mwake_cnt_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion periods

  assign period_end = (state_reg == ST_RUN) && mod_tick &&
    (decim_cnt_reg == decim_ratio(conf_reg[`ADCSEQ_OSR_LSB +: 2], conf_reg[`ADCSEQ_REJ_LSB +: 2]) - 10'h001);
  // First result waits for settling, later ones for one or three periods
  always_comb begin
    if (first_reg) begin
      periods_needed = ctrl_reg[`ADCSEQ_CHOP_BIT] ? 3'(`ADCSEQ_PERIODS_CHOP) : 3'(`ADCSEQ_PERIODS_PLAIN);
    end else begin
      periods_needed = ctrl_reg[`ADCSEQ_CHOP_BIT] ? 3'(`ADCSEQ_NEXT_CHOP) : 3'(`ADCSEQ_NEXT_PLAIN);
    end
  end
  assign periods_met = period_end && (period_cnt_reg == periods_needed - 3'h1);

  // Ticks within the current period
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      decim_cnt_reg <= 10'h000;
    end else if (state_reg != ST_RUN || period_end) begin
      decim_cnt_reg <= 10'h000;
    end else if (mod_tick) begin
      decim_cnt_reg <= decim_cnt_reg + 10'h001;
    end
  end

  // Periods counted toward the next result
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      period_cnt_reg <= 3'h0;
      first_reg <= 1'b1;
    end else if (state_reg != ST_RUN) begin
      period_cnt_reg <= 3'h0;
      first_reg <= 1'b1;
    end else if (periods_met) begin
      period_cnt_reg <= 3'h0;
      first_reg <= 1'b0;
    end else if (period_end) begin
      period_cnt_reg <= period_cnt_reg + 3'h1;
    end
  end

  // Input swap toggles every period while chopping
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chop_swap_out <= 1'b0;
    end else if (state_reg != ST_RUN || !ctrl_reg[`ADCSEQ_CHOP_BIT]) begin
      chop_swap_out <= 1'b0;
    end else if (period_end) begin
      chop_swap_out <= ~chop_swap_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Correction and result

  assign cal_done = cal_busy_reg && (cal_cnt_reg == 7'h01);
  assign single_done = cal_done && !ctrl_reg[`ADCSEQ_CONT_BIT] && (state_reg == ST_RUN);

  // Correction counter runs beside the next period
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cal_busy_reg <= 1'b0;
      cal_cnt_reg <= 7'h00;
    end else if (state_reg != ST_RUN) begin
      cal_busy_reg <= 1'b0;
      cal_cnt_reg <= 7'h00;
    end else if (periods_met) begin
      cal_busy_reg <= 1'b1;
      cal_cnt_reg <= 7'(`ADCSEQ_CAL_CYCLES);
    end else if (cal_busy_reg) begin
      cal_busy_reg <= ~cal_done;
      cal_cnt_reg <= cal_cnt_reg - 7'h01;
    end
  end

  // Result register and update strobes
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_reg <= 16'h0000;
      result_update_out <= 1'b0;
      filter_done_out <= 1'b0;
    end else begin
      filter_done_out <= periods_met;
      result_update_out <= cal_done && (state_reg == ST_RUN);
      if (cal_done && state_reg == ST_RUN) begin
        result_reg <= corrected_data_in;
      end
    end
  end

  // Ready flag: set on update, cleared by reading the result; set wins
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ready_reg <= 1'b0;
    end else if (cal_done && state_reg == ST_RUN) begin
      ready_reg <= 1'b1;
    end else if (rd_result) begin
      ready_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down decode

  // Enables from measure-go, selects and keep bits
  always_comb begin
    power_next.bias_resistor_block = keep_reg[`ADCSEQ_KEEP_BIAS];
    power_next.amplifier_a = keep_reg[`ADCSEQ_KEEP_AMPA] | (go & (src == SRC_SENSOR));
    power_next.amplifier_b = keep_reg[`ADCSEQ_KEEP_AMPB] | (go & (src == SRC_SENSOR));
    power_next.system_clock_source = osc_run;
    power_next.front_gain_stage = keep_reg[`ADCSEQ_KEEP_GAIN] | (go & (src == SRC_TEMP)) |
      (go & (src == SRC_SENSOR || src == SRC_AUX) & ctrl_reg[`ADCSEQ_GAINSEL_BIT]);
    power_next.internal_reference = ~ctrl_reg[`ADCSEQ_BIAS_SOURCE_SELECT_BIT] | keep_reg[`ADCSEQ_KEEP_REF] |
      (go & (src == SRC_TEMP)) |
      (go & (src == SRC_SENSOR || src == SRC_AUX) & ~ctrl_reg[`ADCSEQ_REFSEL_BIT]);
    power_next.converter = go | keep_reg[`ADCSEQ_KEEP_CONV];
    power_next.temp_sensor = keep_reg[`ADCSEQ_KEEP_TEMP] | (go & (src == SRC_TEMP));
  end

  // Registered power enables and modulator enable
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      power_out <= '0;
      mod_clock_en_out <= 1'b0;
    end else begin
      power_out <= power_next;
      mod_clock_en_out <= mod_tick && (state_reg == ST_MOD_WAKE || state_reg == ST_RUN);
    end
  end

endmodule : adcseq_top

// ==== adcseq_monitor.sv ====
// Concurrent checks on the ports of the conversion and power sequencer.
// Assumes binding to adcseq_top with a modulator divider of at least four.
`timescale 1ns/1ps
module adcseq_monitor import adcseq_pkg::*; #(
  parameter int MOD_DIV = 4,
  parameter int CLK_WAKE_CYCLES = 10,
  parameter int MAX_DECIM = 768
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Correction datapath
  input wire logic [15:0] corrected_data_in,
  input wire logic filter_done_out,
  input wire logic result_update_out,
  // Analog control
  input wire logic chop_swap_out,
  input wire logic mod_clock_en_out,
  input wire adcseq_power_type power_out
);
  ////////////////////////////////////////////////////////////////
  // One clock domain, reset disables every check
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  ////////////////////////////////////////////////////////////////
  // Register bus answers
  pready_timing_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("bus answer late");
  pready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("bus answer too long");
  slverr_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without answer");
  rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");

  ////////////////////////////////////////////////////////////////
  // Conversion timing
  update_pulse_a: assert property (result_update_out |=> !result_update_out)
    else $error("update pulse too long");
  correction_gap_a: assert property (filter_done_out |-> ##[60:80] result_update_out)
    else $error("correction time wrong");
  tick_spacing_a: assert property (mod_clock_en_out |=> !mod_clock_en_out [*3])
    else $error("modulator ticks too close");
  done_on_tick_a: assert property (filter_done_out |-> mod_clock_en_out || $past(mod_clock_en_out)
    || $past(mod_clock_en_out, 2))
    else $error("period end off a tick");

  ////////////////////////////////////////////////////////////////
  // Power relations
  conv_osc_a: assert property (power_out.converter |-> power_out.system_clock_source)
    else $error("converter on without clock");
  update_conv_a: assert property (result_update_out |-> $past(power_out.converter))
    else $error("result without converter");
endmodule : adcseq_monitor

// ==== adcseq_top_tb.sv ====
// Self-checking bench of the conversion and power sequencer.
// Assumes adcseq_top with shortened counts and the port checker.
`timescale 1ns/1ps
`include "adcseq_params.svh"
module adcseq_top_tb import adcseq_pkg::*;;
  localparam int DIV = 4; // Shortened modulator divider
  localparam int WAKE = 10; // Shortened clock wake count
  // Design ports
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [15:0] corrected_data_in = 16'h0;
  logic filter_done_out;
  logic result_update_out;
  logic chop_swap_out;
  logic mod_clock_en_out;
  adcseq_power_type power_out;
  // Bookkeeping
  int fail_count = 0;
  int comparisons = 0;
  int toggles = 0;
  logic chop_d = 1'b0;

  adcseq_top #(.MOD_DIV(DIV), .CLK_WAKE_CYCLES(WAKE)) i_adcseq_top (.clock_in(clock_in),
    .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .corrected_data_in(corrected_data_in),
    .filter_done_out(filter_done_out), .result_update_out(result_update_out),
    .chop_swap_out(chop_swap_out), .mod_clock_en_out(mod_clock_en_out), .power_out(power_out));

  ////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clock_in = ~clock_in;

  // Counts changes of the input swap state
  always @(posedge clock_in) begin
    chop_d <= chop_swap_out;
    if (chop_d !== chop_swap_out) begin
      toggles <= toggles + 1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Cycle counts within a tolerance
  task automatic near(input string what, input int exp, input int got, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near

  // A bound that ran out ends the run
  task automatic timeout(input string what);
    fail_count++;
    $display("wrong value wait for %s expected done seen hang", what);
    print_verdict();
  endtask : timeout

  ////////////////////////////////////////////////////////////////
  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      timeout("pready");
    end
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, exp, q);
  endtask : rd

  // Counts edges up to the next result update pulse
  task automatic wait_upd(output int cyc);
    cyc = 0;
    do begin
      @(posedge clock_in);
      cyc++;
    end while (result_update_out !== 1'b1 && cyc < 40000);
    if (cyc >= 40000) begin
      timeout("result");
    end
  endtask : wait_upd

  // Expected block power enables
  function automatic logic [7:0] pwr_exp(input logic go, input logic [7:0] c, input logic [7:0] k);
    logic [1:0] s;
    logic m;
    s = c[4:3];
    m = go & (s == 2'b01 || s == 2'b10);
    return {k[7], k[6] | (go & s == 2'b01), k[5] | (go & s == 2'b01), go | k[4] | k[1],
      k[3] | (go & s == 2'b00) | (m & c[6]), ~c[7] | k[2] | (go & s == 2'b00) | (m & ~c[5]),
      go | k[1], k[0] | (go & s == 2'b00)};
  endfunction : pwr_exp

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic reset_values;
    logic [31:0] q;
    logic e;
    rd("control", `ADCSEQ_CTRL_OFS, 32'h0);
    rd("config", `ADCSEQ_CONF_OFS, 32'h0);
    rd("keep", `ADCSEQ_KEEP_OFS, 32'h0);
    rd("status", `ADCSEQ_STAT_OFS, 32'h4);
    apb(1'b1, 12'h018, 32'h1, q, e);
    check("write error", 32'h1, {31'h0, e});
    apb(1'b0, 12'h018, 32'h0, q, e);
    check("read error", 32'h1, {31'h0, e});
    check("power at reset", 32'h4, {24'h0, power_out});
  endtask : reset_values

  // One conversion in the mode given by the control value
  task automatic run_conv(input logic [7:0] ctl, input logic [5:0] conf, input logic [7:0] keep,
                          input int ratio);
    int cyc;
    int div;
    div = DIV << conf[1:0];
    wr(`ADCSEQ_KEEP_OFS, {24'h0, keep});
    wr(`ADCSEQ_CONF_OFS, {26'h0, conf});
    corrected_data_in <= {ctl, 8'h5a};
    toggles = 0;
    wr(`ADCSEQ_CTRL_OFS, {24'h0, ctl});
    wait_upd(cyc);
    near("first result", (keep[4] ? 0 : WAKE) + 20 * div + (ctl[2] ? 6 : 3) * ratio * div + 70, cyc, 4);
    check("swap seen", {31'h0, ctl[2]}, {31'h0, toggles != 0});
    if (ctl[1]) begin
      wait_upd(cyc);
      near("result spacing", (ctl[2] ? 3 : 1) * ratio * div, cyc, 0);
      wr(`ADCSEQ_CTRL_OFS, 32'h0);
    end
    rd("status done", `ADCSEQ_STAT_OFS, 32'h5);
    rd("control done", `ADCSEQ_CTRL_OFS, ctl[1] ? 32'h0 : {24'h0, ctl & 8'hfe});
    rd("result", `ADCSEQ_RES_OFS, {16'h0, ctl, 8'h5a});
    rd("status read", `ADCSEQ_STAT_OFS, 32'h4);
    check("power idle", {24'h0, pwr_exp(1'b0, ctl, keep)}, {24'h0, power_out});
  endtask : run_conv

  // Power enables for each keep bit, then for the temperature, sensor and auxiliary sources with each select
  task automatic power_scan;
    logic [7:0] c;
    for (int i = 0; i < 8; i++) begin
      wr(`ADCSEQ_KEEP_OFS, 32'h1 << i);
      wr(`ADCSEQ_CTRL_OFS, 32'h80);
      repeat (2) @(posedge clock_in);
      check("power keep", {24'h0, pwr_exp(1'b0, 8'h80, 8'h01 << i)}, {24'h0, power_out});
    end
    wr(`ADCSEQ_KEEP_OFS, 32'h10);
    for (int i = 0; i < 24; i++) begin
      c = {i[2:0], i[4:3], 3'b001};
      wr(`ADCSEQ_CTRL_OFS, {24'h0, c});
      repeat (2) @(posedge clock_in);
      check("power measuring", {24'h0, pwr_exp(1'b1, c, 8'h10)}, {24'h0, power_out});
    end
    wr(`ADCSEQ_CTRL_OFS, 32'h0);
  endtask : power_scan

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'b1;
    reset_values();
    run_conv(8'h09, 6'h2c, 8'h10, 80);
    run_conv(8'h01, 6'h25, 8'h10, 320);
    run_conv(8'h11, 6'h00, 8'h10, 768);
    run_conv(8'h05, 6'h2c, 8'h10, 80);
    run_conv(8'h0b, 6'h2c, 8'h10, 80);
    run_conv(8'h07, 6'h2c, 8'h10, 80);
    wr(`ADCSEQ_KEEP_OFS, 32'h0);
    wr(`ADCSEQ_CONF_OFS, 32'h0);
    rd("config guarded", `ADCSEQ_CONF_OFS, 32'h2c);
    run_conv(8'h01, 6'h2c, 8'h00, 80);
    power_scan();
    print_verdict();
  end
endmodule : adcseq_top_tb

bind adcseq_top adcseq_monitor #(.MOD_DIV(MOD_DIV), .CLK_WAKE_CYCLES(CLK_WAKE_CYCLES),
  .MAX_DECIM(MAX_DECIM)) i_adcseq_monitor (.clock_in(clock_in), .rstn_in(rstn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .corrected_data_in(corrected_data_in),
  .filter_done_out(filter_done_out), .result_update_out(result_update_out),
  .chop_swap_out(chop_swap_out), .mod_clock_en_out(mod_clock_en_out), .power_out(power_out));
